// *** cbd_far_side.sv ***
// Purpose : Model of the pushbutton and the network side of the decoder.
// Assumes : Everything changes by non-blocking assignment after a pclk rising edge.
// Notes   : The button line has a pull-up, so a released button reads high.
`default_nettype none
module cbd_far_side (
   input  wire logic pclk,
   output logic      button_n,
   output logic      net_wake_start,
   output logic      net_asleep,
   output logic      nid_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      button_n       = 1'b1;
      net_wake_start = 1'b0;
      net_asleep     = 1'b0;
      nid_rx         = 1'b0;
   end
   // ==========================================================
   // Stimulus
   // Presses are seven cycles apart, so four of them fit well inside one window.
   task automatic press(input int n);
      repeat (n) begin
         @(posedge pclk) button_n <= 1'b0;
         repeat (3) @(posedge pclk);
         button_n <= 1'b1;
         repeat (3) @(posedge pclk);
      end
   endtask : press
   task automatic wake_pulse();
      @(posedge pclk) net_wake_start <= 1'b1;
      @(posedge pclk) net_wake_start <= 1'b0;
   endtask : wake_pulse
   task automatic rx_pulse();
      @(posedge pclk) nid_rx <= 1'b1;
      @(posedge pclk) nid_rx <= 1'b0;
   endtask : rx_pulse
   task automatic set_asleep(input logic v);
      @(posedge pclk) net_asleep <= v;
   endtask : set_asleep
endmodule : cbd_far_side
`default_nettype wire

// *** cbd_pkg.sv ***
// Purpose : Shared constants and types for the commissioning button decoder.
// Assumes : 100 MHz pclk, APB register access with 32-bit aligned words.
// Notes   : Times are kept in milliseconds; cycle counts derive from them.
`default_nettype none
package cbd_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0]  CTRL_OFS       = 8'h00;
   localparam logic [7:0]  SOFT_OFS       = 8'h04;
   localparam logic [7:0]  STAT_OFS       = 8'h08;
   localparam int          CTRL_EN_BIT    = 0;
   localparam int          CTRL_SLP_LSB   = 1;
   localparam int          CTRL_NOM_BIT   = 3;
   localparam int          CTRL_API_BIT   = 4;
   localparam int          CTRL_LED_BIT   = 5;
   localparam logic [5:0]  CTRL_RST       = 6'h21;
   localparam logic [1:0]  SLP_NONE       = 2'h0;
   localparam logic [1:0]  SLP_ASYNC      = 2'h1;
   localparam logic [1:0]  SLP_SYNC       = 2'h2;
   localparam logic [2:0]  PRESS_ONE      = 3'h1;
   localparam logic [2:0]  PRESS_TWO      = 3'h2;
   localparam logic [2:0]  PRESS_FOUR     = 3'h4;
   localparam logic [2:0]  PRESS_MAX      = 3'h7;
   localparam logic [7:0]  NID_FRAME_TYPE = 8'h95;
   // ==========================================================
   // Timing
   localparam longint unsigned CLK_HZ     = 100_000_000;
   localparam longint unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam longint unsigned WINDOW_MS  = 2000;
   localparam longint unsigned AWAKE_MS   = 30000;
   localparam longint unsigned BLINK_MS   = 1000;
   localparam longint unsigned RATE_MS    = 50;
   localparam longint unsigned WINDOW_CYC = WINDOW_MS * CYC_PER_MS;
   localparam longint unsigned AWAKE_CYC  = AWAKE_MS * CYC_PER_MS;
   localparam longint unsigned BLINK_CYC  = BLINK_MS * CYC_PER_MS;
   localparam longint unsigned RATE_CYC   = RATE_MS * CYC_PER_MS;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b01,
      SEQ_COUNT = 2'b10
   } seq_state_t;
endpackage : cbd_pkg
`default_nettype wire

// *** cbd_timer.sv ***
// Purpose : Loadable down-counter with busy level and expiry pulse.
// Assumes : Same clock and clock enable as the parent.
// Notes   : Load wins over stop; expire pulses when the count decrements to zero, not when stop clears it.
`default_nettype none
module cbd_timer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        load,
   input  wire logic        stop,
   input  wire logic [31:0] load_val,
   output logic             busy,
   output logic             expire
);
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic        exp_r;
   logic        exp_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      exp_nxt = 1'b0;
      if (load) begin
         cnt_nxt = load_val;
      end else if (stop) begin
         cnt_nxt = 32'h0000_0000;
      end else if (cnt_r != 32'h0000_0000) begin
         cnt_nxt = cnt_r - 32'h0000_0001;
         exp_nxt = (cnt_r == 32'h0000_0001);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 32'h0000_0000;
         exp_r <= 1'b0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
         exp_r <= exp_nxt;
      end
   end

   assign busy   = (cnt_r != 32'h0000_0000);
   assign expire = exp_r;
endmodule : cbd_timer
`default_nettype wire

// *** commissioning_button_decoder.sv ***
// Purpose : Decodes commissioning pushbutton press sequences into actions.
// Assumes : APB slave on pclk; button pin is asynchronous and active low.
// Notes   : Long counts are parameters so simulation can shorten them.
`default_nettype none
module commissioning_button_decoder
   import cbd_pkg::*;
#(
   parameter logic [31:0] WIN_CYCLES   = 32'(WINDOW_CYC),
   parameter logic [31:0] AWAKE_CYCLES = 32'(AWAKE_CYC),
   parameter logic [31:0] BLINK_CYCLES = 32'(BLINK_CYC),
   parameter logic [31:0] RATE_CYCLES  = 32'(RATE_CYC)
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        button_n,
   input  wire logic        net_wake_start,
   input  wire logic        net_asleep,
   input  wire logic        nid_rx,
   output logic             nid_tx,
   output logic             stay_awake,
   output logic             nominate_coord,
   output logic             restore_defaults_command,
   output logic             assoc_led,
   output logic             nid_indicator,
   output logic [7:0]       nid_frame_type
);
   // ==========================================================
   // State
   seq_state_t  st_r, st_nxt;
   logic [5:0]  ctrl_r, ctrl_nxt;
   logic [2:0]  cnt_r, cnt_nxt;
   logic [2:0]  soft_cnt_r, soft_cnt_nxt;
   logic        soft_pend_r, soft_pend_nxt;
   logic        pend_r, pend_nxt;
   logic        tx_r, tx_nxt;
   logic        nom_r, nom_nxt;
   logic        rst_cmd_r, rst_cmd_nxt;
   logic        ind_r, ind_nxt;
   logic [7:0]  ftype_r, ftype_nxt;
   logic        led_r, led_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        sync1_r, sync2_r, prev_r;
   logic        press_edge, mapped, wr_en;
   logic        disp, win_load, win_busy, win_exp;
   logic        awake_load, awake_stop, blink_load, blink_busy;
   logic        rate_load, rate_exp;
   logic [2:0]  disp_cnt;
   logic [1:0]  slp;

   assign slp = ctrl_r[CTRL_SLP_LSB +: 2];

   // ==========================================================
   // Button synchroniser; the first stage feeds only the second.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         prev_r  <= 1'b1;
      end else if (ce) begin
         sync1_r <= button_n;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end
   // No debounce: contact bounce inside the window would add presses.
   assign press_edge = prev_r & ~sync2_r & ctrl_r[CTRL_EN_BIT];

   // ==========================================================
   // APB decode; zero wait states.
   assign mapped  = (paddr == CTRL_OFS) || (paddr == SOFT_OFS) || (paddr == STAT_OFS);
   assign wr_en   = psel & penable & pwrite & mapped;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = rdata_r;

   // ==========================================================
   // Timers
   cbd_timer u_win (
      .pclk(pclk), .presetn(presetn), .ce(ce), .load(win_load), .stop(1'b0),
      .load_val(WIN_CYCLES), .busy(win_busy), .expire(win_exp));
   cbd_timer u_awake (
      .pclk(pclk), .presetn(presetn), .ce(ce), .load(awake_load), .stop(awake_stop),
      .load_val(AWAKE_CYCLES), .busy(stay_awake), .expire());
   cbd_timer u_blink (
      .pclk(pclk), .presetn(presetn), .ce(ce), .load(blink_load), .stop(1'b0),
      .load_val(BLINK_CYCLES), .busy(blink_busy), .expire());
   cbd_timer u_rate (
      .pclk(pclk), .presetn(presetn), .ce(ce), .load(rate_load), .stop(1'b0),
      .load_val(RATE_CYCLES), .busy(), .expire(rate_exp));

   // ==========================================================
   // Sequence counter and action dispatch
   always_comb begin
      st_nxt        = st_r;
      cnt_nxt       = cnt_r;
      win_load      = 1'b0;
      disp          = 1'b0;
      disp_cnt      = cnt_r;
      soft_pend_nxt = soft_pend_r;
      soft_cnt_nxt  = soft_cnt_r;
      case (st_r)
         SEQ_IDLE: begin
            if (press_edge) begin
               st_nxt   = SEQ_COUNT;
               cnt_nxt  = PRESS_ONE;
               win_load = 1'b1;
            end
         end
         SEQ_COUNT: begin
            if (win_exp) begin
               disp    = 1'b1;
               st_nxt  = SEQ_IDLE;
               cnt_nxt = 3'h0;
            end else if (press_edge && cnt_r != PRESS_MAX) begin
               cnt_nxt = cnt_r + 3'h1;
            end
         end
         default: begin
            st_nxt  = SEQ_IDLE;
            cnt_nxt = 3'h0;
         end
      endcase
      // A software request waits one slot if a physical sequence dispatches.
      if (soft_pend_r && !disp) begin
         disp          = 1'b1;
         disp_cnt      = soft_cnt_r;
         soft_pend_nxt = 1'b0;
      end
      if (wr_en && paddr == SOFT_OFS && pwdata[2:0] != 3'h0) begin
         soft_pend_nxt = 1'b1;
         soft_cnt_nxt  = pwdata[2:0];
      end
   end

   always_comb begin
      tx_nxt      = pend_r & net_wake_start;
      pend_nxt    = pend_r & ~net_wake_start;
      nom_nxt     = 1'b0;
      rst_cmd_nxt = 1'b0;
      awake_load  = 1'b0;
      awake_stop  = (slp == SLP_SYNC) & net_asleep;
      if (disp) begin
         case (disp_cnt)
            PRESS_ONE: begin
               if (slp == SLP_ASYNC) begin
                  awake_load = 1'b1;
                  tx_nxt     = 1'b1;
               end else if (slp == SLP_SYNC) begin
                  awake_load = 1'b1;
                  pend_nxt   = 1'b1;
               end else begin
                  tx_nxt = 1'b1;
               end
            end
            PRESS_TWO: nom_nxt = (slp == SLP_SYNC) & ctrl_r[CTRL_NOM_BIT];
            PRESS_FOUR: rst_cmd_nxt = 1'b1;
            default: nom_nxt = 1'b0;
         endcase
      end
   end

   // ==========================================================
   // Receive side: LED blink and indicator frame
   assign blink_load = nid_rx & ctrl_r[CTRL_LED_BIT];
   assign rate_load  = blink_load | (rate_exp & blink_busy);

   always_comb begin
      ind_nxt   = nid_rx & ctrl_r[CTRL_API_BIT];
      ftype_nxt = ftype_r;
      if (ind_nxt) begin
         ftype_nxt = NID_FRAME_TYPE;
      end
      // The LED rests on as a power indicator between blink bursts.
      led_nxt = 1'b1;
      if (blink_busy) begin
         led_nxt = rate_exp ? ~led_r : led_r;
      end
   end

   // ==========================================================
   // Registers and read mux
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_en && paddr == CTRL_OFS) begin
         ctrl_nxt = pwdata[5:0];
      end
      rdata_nxt = rdata_r;
      if (psel && !penable) begin
         case (paddr)
            CTRL_OFS: rdata_nxt = {26'h000_0000, ctrl_r};
            SOFT_OFS: rdata_nxt = {28'h000_0000, soft_pend_r, soft_cnt_r};
            STAT_OFS: rdata_nxt = {24'h00_0000, led_r, blink_busy, pend_r,
                                   stay_awake, win_busy, cnt_r};
            default:  rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r        <= SEQ_IDLE;
         ctrl_r      <= CTRL_RST;
         cnt_r       <= 3'h0;
         soft_cnt_r  <= 3'h0;
         soft_pend_r <= 1'b0;
         pend_r      <= 1'b0;
         tx_r        <= 1'b0;
         nom_r       <= 1'b0;
         rst_cmd_r   <= 1'b0;
         ind_r       <= 1'b0;
         ftype_r     <= 8'h00;
         led_r       <= 1'b1;
         rdata_r     <= 32'h0000_0000;
      end else if (ce) begin
         st_r        <= st_nxt;
         ctrl_r      <= ctrl_nxt;
         cnt_r       <= cnt_nxt;
         soft_cnt_r  <= soft_cnt_nxt;
         soft_pend_r <= soft_pend_nxt;
         pend_r      <= pend_nxt;
         tx_r        <= tx_nxt;
         nom_r       <= nom_nxt;
         rst_cmd_r   <= rst_cmd_nxt;
         ind_r       <= ind_nxt;
         ftype_r     <= ftype_nxt;
         led_r       <= led_nxt;
         rdata_r     <= rdata_nxt;
      end
   end

   assign nid_tx                   = tx_r;
   assign nominate_coord           = nom_r;
   assign restore_defaults_command = rst_cmd_r;
   assign assoc_led                = led_r;
   assign nid_indicator            = ind_r;
   assign nid_frame_type           = ftype_r;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !ce);

   sequence soft_write_s;
      wr_en && paddr == SOFT_OFS && pwdata[2:0] == PRESS_FOUR && !soft_pend_r;
   endsequence
   sequence soft_taken_s;
      soft_pend_r ##1 !soft_pend_r;
   endsequence

   btn_disabled_a: assert property (st_r == SEQ_IDLE && !ctrl_r[CTRL_EN_BIT]
      |=> st_r == SEQ_IDLE)
      else $error("sequence started while button disabled");
   single_plain_a: assert property (disp && disp_cnt == PRESS_ONE
      && slp == SLP_NONE |=> nid_tx)
      else $error("no broadcast on single press");
   single_async_a: assert property (disp && disp_cnt == PRESS_ONE
      && slp == SLP_ASYNC |=> nid_tx ##0 stay_awake [*8])
      else $error("async single press not awake with broadcast");
   sync_sleep_a: assert property (slp == SLP_SYNC && net_asleep && !awake_load
      |=> !stay_awake)
      else $error("awake hold survived network sleep");
   sync_queue_a: assert property (disp && disp_cnt == PRESS_ONE
      && slp == SLP_SYNC && !pend_r |=> !nid_tx && pend_r)
      else $error("sync broadcast not queued");
   queue_release_a: assert property (pend_r && net_wake_start |=> nid_tx)
      else $error("queued broadcast not released");
   two_press_a: assert property (disp && disp_cnt == PRESS_TWO
      |=> nominate_coord == ($past(slp) == SLP_SYNC && $past(ctrl_r[CTRL_NOM_BIT])))
      else $error("nomination mismatch");
   four_press_a: assert property (disp && disp_cnt == PRESS_FOUR
      |=> restore_defaults_command ##1 !restore_defaults_command)
      else $error("restore command not a single pulse");
   blink_len_a: assert property (blink_load |=> blink_busy [*8])
      else $error("blink burst too short");
   indicator_a: assert property (nid_rx && ctrl_r[CTRL_API_BIT]
      |=> nid_indicator && nid_frame_type == 8'h95)
      else $error("indicator frame missing");
   soft_req_a: assert property (soft_write_s ##1 soft_taken_s
      |-> restore_defaults_command)
      else $error("software four presses did not restore");
   window_a: assert property (st_r == SEQ_IDLE && press_edge
      |=> st_r == SEQ_COUNT && cnt_r == PRESS_ONE && win_busy)
      else $error("window not started on first press");
endmodule : commissioning_button_decoder
`default_nettype wire

// *** tb_top.sv ***
// Purpose : Self-checking bench for the commissioning button decoder.
// Assumes : Shortened counts: window 40, awake 100, blink 60, rate 5 cycles.
// Notes   : Action pulses are counted by monitors and judged after each scenario.
`default_nettype none
module tb_top;
   import cbd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, nid_frame_type;
   logic [31:0] pwdata, prdata, rd;
   logic        button_n, net_wake_start, net_asleep, nid_rx, nid_tx, stay_awake;
   logic        nominate_coord, restore_defaults_command, assoc_led, nid_indicator;
   logic        led_q, err, clr_go;
   int          err_total, n_tests, n_tx, n_nom, n_rst, n_ind, n_tog;
   commissioning_button_decoder #(
      .WIN_CYCLES(32'h0000_0028), .AWAKE_CYCLES(32'h0000_0064),
      .BLINK_CYCLES(32'h0000_003C), .RATE_CYCLES(32'h0000_0005)
   ) u_commissioning_button_decoder (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .button_n(button_n),
      .net_wake_start(net_wake_start), .net_asleep(net_asleep), .nid_rx(nid_rx),
      .nid_tx(nid_tx), .stay_awake(stay_awake), .nominate_coord(nominate_coord),
      .restore_defaults_command(restore_defaults_command), .assoc_led(assoc_led),
      .nid_indicator(nid_indicator), .nid_frame_type(nid_frame_type));
   cbd_far_side u_cbd_far_side (
      .pclk(pclk), .button_n(button_n), .net_wake_start(net_wake_start),
      .net_asleep(net_asleep), .nid_rx(nid_rx));
   always #5 pclk = ~pclk;
   // ==========================================================
   // Monitors
   // Only this process writes the counters, so a clear never races a count.
   always @(posedge pclk) begin
      if (clr_go) begin
         n_tx  <= 0;
         n_nom <= 0;
         n_rst <= 0;
         n_ind <= 0;
         n_tog <= 0;
      end else begin
         n_tx  <= n_tx + int'(nid_tx === 1'b1);
         n_nom <= n_nom + int'(nominate_coord === 1'b1);
         n_rst <= n_rst + int'(restore_defaults_command === 1'b1);
         n_ind <= n_ind + int'(nid_indicator === 1'b1);
         n_tog <= n_tog + int'(assoc_led !== led_q);
      end
      led_q <= assoc_led;
   end
   // ==========================================================
   // Shared tasks
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   // Wait states are honoured; only the watchdog ends a wait that never finishes.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic clr();
      @(posedge pclk) clr_go <= 1'b1;
      @(posedge pclk) clr_go <= 1'b0;
   endtask : clr
   // Writes the settings, presses, then lets the window run out and the action land.
   task automatic seq(input logic [31:0] ctrl, input int n);
      apb(1'b1, CTRL_OFS, ctrl);
      clr();
      u_cbd_far_side.press(n);
      repeat (60) @(posedge pclk);
   endtask : seq
   // ==========================================================
   // Scenarios
   task automatic s_regs();
      apb(1'b0, CTRL_OFS, 32'h0000_0000);
      check("ctrl reset", rd, 32'h0000_0021);
      apb(1'b0, 8'h40, 32'h0000_0000);
      check("unmapped err", 32'(err), 32'h0000_0001);
   endtask : s_regs
   task automatic s_plain();
      seq(32'h0000_0021, 1);
      check("plain tx", n_tx, 1);
      seq(32'h0000_0021, 3);
      check("three presses", n_tx + n_nom + n_rst, 0);
      seq(32'h0000_0020, 1);
      check("disabled tx", n_tx, 0);
   endtask : s_plain
   task automatic s_async();
      seq(32'h0000_0023, 1);
      check("async tx", n_tx, 1);
      check("async awake", 32'(stay_awake), 1);
      repeat (100) @(posedge pclk);
      check("async awake end", 32'(stay_awake), 0);
   endtask : s_async
   task automatic s_sync();
      seq(32'h0000_0025, 1);
      check("sync held", n_tx, 0);
      check("sync awake", 32'(stay_awake), 1);
      apb(1'b0, STAT_OFS, 32'h0000_0000);
      check("sync status", rd, 32'h0000_00B0);
      u_cbd_far_side.wake_pulse();
      repeat (3) @(posedge pclk);
      check("sync released", n_tx, 1);
      u_cbd_far_side.set_asleep(1'b1);
      repeat (3) @(posedge pclk);
      check("sync asleep", 32'(stay_awake), 0);
      u_cbd_far_side.set_asleep(1'b0);
   endtask : s_sync
   task automatic s_two_four();
      seq(32'h0000_0029, 2);
      check("two no sync", n_nom, 0);
      seq(32'h0000_002D, 2);
      check("two sync nom", n_nom, 1);
      seq(32'h0000_0025, 4);
      check("four restore", n_rst, 1);
   endtask : s_two_four
   task automatic s_rx();
      apb(1'b1, CTRL_OFS, 32'h0000_0031);
      clr();
      u_cbd_far_side.rx_pulse();
      repeat (3) @(posedge pclk);
      check("indicator", n_ind, 1);
      check("frame type", 32'(nid_frame_type), 32'(NID_FRAME_TYPE));
      repeat (50) @(posedge pclk);
      check("blinking", 32'(n_tog > 4), 1);
      repeat (20) @(posedge pclk);
      clr();
      repeat (30) @(posedge pclk);
      check("blink over", n_tog, 0);
   endtask : s_rx
   task automatic s_soft();
      apb(1'b1, CTRL_OFS, 32'h0000_0021);
      clr();
      apb(1'b1, SOFT_OFS, 32'h0000_0004);
      repeat (5) @(posedge pclk);
      check("soft restore", n_rst, 1);
      apb(1'b1, SOFT_OFS, 32'h0000_0001);
      repeat (5) @(posedge pclk);
      check("soft tx", n_tx, 1);
   endtask : s_soft
   // Clock enable low must hold the running window, so the action lands only after it rises.
   task automatic s_freeze();
      apb(1'b1, CTRL_OFS, 32'h0000_0021);
      clr();
      u_cbd_far_side.press(1);
      @(posedge pclk) ce <= 1'b0;
      repeat (50) @(posedge pclk);
      check("frozen tx", n_tx, 0);
      ce <= 1'b1;
      repeat (60) @(posedge pclk);
      check("thawed tx", n_tx, 1);
   endtask : s_freeze
   // ==========================================================
   // Verdict
   task automatic close_out();
      $display("tests %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   initial begin
      #60000;
      err_total++;
      close_out();
   end
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      err_total = 0;
      n_tests = 0;
      clr_go = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      s_regs();
      s_plain();
      s_async();
      s_sync();
      s_two_four();
      s_rx();
      s_soft();
      s_freeze();
      close_out();
   end
endmodule : tb_top
`default_nettype wire
